// ### fcf_pkg.sv
package fcf_pkg;
   localparam int CLK_MHZ = 100;
   localparam int POWER_UP_WRITE_DELAY_MS = 20;
   // Longest time, counted in whole reference clock cycles
   localparam int POWER_UP_WRITE_CYCLES =
      POWER_UP_WRITE_DELAY_MS * 1000 * CLK_MHZ;
   localparam int WCNT_W = 22;
   localparam int SYNC_W = 14;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int PAGE_W = 13;
   localparam int OFFS_W = 11;
   localparam int ADDR_W = 24;
   localparam int TOP5_W = 5;
   localparam int PAGE10_W = 10;
   localparam logic [1:0] ADDR_BYTES = 2'h3;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic MODE3_AT_RESET = 1'b1;
   localparam logic OE_N_RESET = 1'b1;
   localparam logic [4:0] DUMMY_NONE = 5'h00;
   localparam logic [4:0] DUMMY_ONE = 5'h01;
   localparam logic [4:0] DUMMY_TWO = 5'h02;
   localparam logic [4:0] DUMMY_FOUR = 5'h04;
   localparam logic [4:0] DUMMY_NINETEEN = 5'h13;

   localparam logic [7:0] OP_03 = 8'h03;
   localparam logic [7:0] OP_0B = 8'h0B;
   localparam logic [7:0] OP_50 = 8'h50;
   localparam logic [7:0] OP_53 = 8'h53;
   localparam logic [7:0] OP_54 = 8'h54;
   localparam logic [7:0] OP_55 = 8'h55;
   localparam logic [7:0] OP_56 = 8'h56;
   localparam logic [7:0] OP_58 = 8'h58;
   localparam logic [7:0] OP_59 = 8'h59;
   localparam logic [7:0] OP_60 = 8'h60;
   localparam logic [7:0] OP_61 = 8'h61;
   localparam logic [7:0] OP_77 = 8'h77;
   localparam logic [7:0] OP_7C = 8'h7C;
   localparam logic [7:0] OP_81 = 8'h81;
   localparam logic [7:0] OP_82 = 8'h82;
   localparam logic [7:0] OP_83 = 8'h83;
   localparam logic [7:0] OP_84 = 8'h84;
   localparam logic [7:0] OP_85 = 8'h85;
   localparam logic [7:0] OP_86 = 8'h86;
   localparam logic [7:0] OP_87 = 8'h87;
   localparam logic [7:0] OP_88 = 8'h88;
   localparam logic [7:0] OP_89 = 8'h89;
   localparam logic [7:0] OP_D1 = 8'hD1;
   localparam logic [7:0] OP_D2 = 8'hD2;
   localparam logic [7:0] OP_D3 = 8'hD3;
   localparam logic [7:0] OP_D4 = 8'hD4;
   localparam logic [7:0] OP_D6 = 8'hD6;
   localparam logic [7:0] OP_D7 = 8'hD7;
   localparam logic [7:0] OP_E8 = 8'hE8;

   typedef enum {ST_POR, ST_STANDBY, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA,
                 ST_IGNORE} fcf_state_type;
   typedef enum {AK_PAGE_BYTE, AK_BUFFER, AK_PAGE, AK_PAGE10, AK_TOP5,
                 AK_DONT_CARE, AK_ABSENT} fcf_addr_type;

   function automatic fcf_addr_type fcf_addr_kind(input logic [7:0] op);
      case (op)
         OP_03, OP_0B, OP_82, OP_85, OP_D2, OP_E8: return AK_PAGE_BYTE;
         OP_54, OP_56, OP_84, OP_87, OP_D1, OP_D3, OP_D4, OP_D6:
            return AK_BUFFER;
         OP_53, OP_55, OP_58, OP_59, OP_60, OP_61, OP_81, OP_83, OP_86,
         OP_88, OP_89: return AK_PAGE;
         OP_50: return AK_PAGE10;
         OP_7C: return AK_TOP5;
         OP_77: return AK_DONT_CARE;
         default: return AK_ABSENT;
      endcase
   endfunction

   function automatic logic [4:0] fcf_dummy(input logic [7:0] op,
                                            input logic byte_mode);
      case (op)
         OP_0B, OP_D4, OP_D6: return DUMMY_ONE;
         OP_D2, OP_E8: return byte_mode ? DUMMY_NINETEEN : DUMMY_FOUR;
         OP_77: return byte_mode ? DUMMY_FOUR : DUMMY_NONE;
         OP_54, OP_56, OP_D7: return byte_mode ? DUMMY_TWO : DUMMY_NONE;
         default: return DUMMY_NONE;
      endcase
   endfunction

   function automatic logic fcf_is_write(input logic [7:0] op);
      case (op)
         OP_50, OP_58, OP_59, OP_7C, OP_81, OP_82, OP_83, OP_85, OP_86,
         OP_88, OP_89: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
endpackage

// ### fcf_sync.sv
`timescale 1ns/10ps
module fcf_sync
   import fcf_pkg::*;
#(
   parameter int W = SYNC_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   always_comb begin
      nxt_meta = ce ? d : meta_ff;
      nxt_q = ce ? meta_ff : q_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_ff <= '0;
         q_ff <= '0;
      end else begin
         meta_ff <= nxt_meta;
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule

// ### fcf_fifo.sv
`timescale 1ns/10ps
module fcf_fifo
   import fcf_pkg::*;
#(
   parameter int W = BYTE_W,
   parameter int D = FIFO_DEPTH
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_ff [D];
   logic [AW:0] wp_ff;
   logic [AW:0] rp_ff;
   logic [AW:0] nxt_wp;
   logic [AW:0] nxt_rp;
   logic push;
   logic pop;

   always_comb begin
      in_ready = !((wp_ff[AW] != rp_ff[AW]) &&
                   (wp_ff[AW-1:0] == rp_ff[AW-1:0]));
      out_valid = (wp_ff != rp_ff);
      push = ce && in_valid && in_ready;
      pop = ce && out_valid && out_ready;
      nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
      nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wp_ff <= '0;
         rp_ff <= '0;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
      end
   end

   // Storage needs no reset; only pointers define validity
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wp_ff[AW-1:0]] <= in_data;
      end
   end

   assign out_data = mem_ff[rp_ff[AW-1:0]];
endmodule

// ### fcf_framer.sv
`timescale 1ns/10ps
// Behaviour
// (RL1) Page-and-byte opcodes: 13-bit page then 11-bit offset in address.
// (RL2) Buffer opcodes keep 11 offset bits; 7Ch keeps top five page bits.
// (RL3) Filler bytes after address per opcode and port width.
// (RL4) After power-up or reset: clock mode 3, data outputs high-impedance.
// (RL5) New instruction decoded only after falling chip select.
// (RL6) Each chip select fall picks mode 0 or 3 from idle clock level.
// (RL7) Host waits 50 us after supply minimum before selecting for reads.
// (RL8) While internal power-on reset is active, ignore all commands.
// (RL9) Host waits up to 20 ms after threshold before program or erase.
// (RL10) After power-up completes the device sits in standby.
// (RL11) Host polls ready/busy for program and erase completion.
// (RL12) Byte port: clock, select, 8 lanes; serial: clock, input, select.
// (RL13) Serial bytes arrive MSB first; byte port takes a byte per clock.
module fcf_framer
   import fcf_pkg::*;
#(
   parameter int POWER_UP_WRITE_CNT = POWER_UP_WRITE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic por_active,
   input wire logic cs_n,
   input wire logic ser_clk,
   input wire logic ser_in,
   input wire logic byte_clk,
   input wire logic byte_sel,
   input wire logic [7:0] byte_port_lanes_in,
   output logic ser_out,
   output logic ser_out_oe_n,
   output logic [7:0] byte_port_lanes_out,
   output logic byte_port_lanes_oe_n,
   output logic clk_mode3,
   output logic standby,
   output logic write_allowed,
   output logic ready_busy,
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [PAGE_W-1:0] cmd_page,
   output logic [OFFS_W-1:0] cmd_offset,
   output logic cmd_rejected,
   output logic data_valid,
   input wire logic data_ready,
   output logic [7:0] data_byte
);
   logic [SYNC_W-1:0] sync_q;
   logic por_s;
   logic cs_s;
   logic sclk_s;
   logic si_s;
   logic bclk_s;
   logic bsel_s;
   logic [7:0] lanes_s;

   fcf_sync #(.W(SYNC_W)) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .ce(ce),
      .d({por_active, cs_n, ser_clk, ser_in, byte_clk, byte_sel,
          byte_port_lanes_in}),
      .q(sync_q)
   );
   assign {por_s, cs_s, sclk_s, si_s, bclk_s, bsel_s, lanes_s} = sync_q;

   fcf_state_type state_ff, nxt_state;
   logic lclk_d_ff, nxt_lclk_d;
   logic cs_d_ff, nxt_cs_d;
   logic mode_byte_ff, nxt_mode_byte;
   logic [6:0] shift_ff, nxt_shift;
   logic [2:0] bitcnt_ff, nxt_bitcnt;
   logic [7:0] opcode_ff, nxt_opcode;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [1:0] acnt_ff, nxt_acnt;
   logic [4:0] dcnt_ff, nxt_dcnt;
   logic [WCNT_W-1:0] wcnt_ff, nxt_wcnt;
   logic write_ok_ff, nxt_write_ok;
   logic mode3_ff, nxt_mode3;
   logic standby_ff, nxt_standby;
   logic ready_ff, nxt_ready;
   logic cmd_valid_ff, nxt_cmd_valid;
   logic [7:0] cmd_opcode_ff, nxt_cmd_opcode;
   logic [PAGE_W-1:0] cmd_page_ff, nxt_cmd_page;
   logic [OFFS_W-1:0] cmd_offset_ff, nxt_cmd_offset;
   logic reject_ff, nxt_reject;
   logic so_oe_n_ff;
   logic lanes_oe_n_ff;

   logic lclk_s;
   logic lclk_rise;
   logic cs_fall;
   logic cs_rise;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [ADDR_W-1:0] addr_full;
   logic [4:0] dummy_need;
   logic fifo_in_valid;
   logic fifo_in_ready;

   always_comb begin
      lclk_s = bsel_s ? bclk_s : sclk_s;
      lclk_rise = lclk_s && !lclk_d_ff;
      cs_fall = !cs_s && cs_d_ff;
      cs_rise = cs_s && !cs_d_ff;
      nxt_lclk_d = lclk_s;
      nxt_cs_d = cs_s;
      nxt_state = state_ff;
      nxt_mode_byte = mode_byte_ff;
      nxt_shift = shift_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_opcode = opcode_ff;
      nxt_addr = addr_ff;
      nxt_acnt = acnt_ff;
      nxt_dcnt = dcnt_ff;
      nxt_mode3 = mode3_ff;
      nxt_standby = standby_ff;
      nxt_cmd_valid = 1'b0;
      nxt_cmd_opcode = cmd_opcode_ff;
      nxt_cmd_page = cmd_page_ff;
      nxt_cmd_offset = cmd_offset_ff;
      nxt_reject = 1'b0;
      fifo_in_valid = 1'b0;
      byte_done = 1'b0;
      // (RL12) (RL13) Lanes or serial bit, MSB first
      rx_byte = mode_byte_ff ? lanes_s : {shift_ff, si_s};
      if (lclk_rise && !cs_s) begin
         if (mode_byte_ff) begin
            byte_done = 1'b1;
         end else begin
            nxt_shift = {shift_ff[5:0], si_s};
            nxt_bitcnt = bitcnt_ff + 1'b1;
            byte_done = (bitcnt_ff == BIT_LAST);
         end
      end
      addr_full = {addr_ff[ADDR_W-9:0], rx_byte};
      dummy_need = fcf_dummy(opcode_ff, mode_byte_ff);
      // (RL1) page then offset field split
      nxt_cmd_page = addr_full[ADDR_W-1:OFFS_W];
      nxt_cmd_offset = addr_full[OFFS_W-1:0];
      case (fcf_addr_kind(opcode_ff))
         // (RL2) buffer and top-five masking
         AK_BUFFER: nxt_cmd_page = '0;
         AK_TOP5: begin
            nxt_cmd_page = {addr_full[ADDR_W-1 -: TOP5_W],
                            {(PAGE_W-TOP5_W){1'b0}}};
            nxt_cmd_offset = '0;
         end
         AK_PAGE10: begin
            nxt_cmd_page = {addr_full[ADDR_W-1 -: PAGE10_W],
                            {(PAGE_W-PAGE10_W){1'b0}}};
            nxt_cmd_offset = '0;
         end
         AK_PAGE: nxt_cmd_offset = '0;
         AK_PAGE_BYTE: nxt_cmd_offset = addr_full[OFFS_W-1:0];
         default: begin
            nxt_cmd_page = '0;
            nxt_cmd_offset = '0;
         end
      endcase
      if (state_ff != ST_ADDR) begin
         nxt_cmd_page = cmd_page_ff;
         nxt_cmd_offset = cmd_offset_ff;
      end
      case (state_ff)
         ST_POR: begin
            if (!por_s) begin
               // (RL10) standby after power-up
               nxt_state = ST_STANDBY;
               nxt_standby = 1'b1;
            end
         end
         ST_STANDBY: begin
            // (RL5) start only on select fall
            if (cs_fall) begin
               nxt_state = ST_OPCODE;
               nxt_standby = 1'b0;
               nxt_bitcnt = '0;
               nxt_mode_byte = bsel_s;
               // (RL6) mode from idle clock
               nxt_mode3 = lclk_s;
            end
         end
         ST_OPCODE: begin
            if (byte_done) begin
               nxt_opcode = rx_byte;
               nxt_cmd_opcode = rx_byte;
               nxt_acnt = '0;
               nxt_dcnt = fcf_dummy(rx_byte, mode_byte_ff);
               if (fcf_is_write(rx_byte) && !write_ok_ff) begin
                  nxt_reject = 1'b1;
                  nxt_state = ST_IGNORE;
               end else if (fcf_addr_kind(rx_byte) != AK_ABSENT) begin
                  nxt_state = ST_ADDR;
               end else if (fcf_dummy(rx_byte, mode_byte_ff) != DUMMY_NONE)
               begin
                  nxt_state = ST_DUMMY;
               end else begin
                  nxt_state = ST_DATA;
                  nxt_cmd_valid = 1'b1;
                  nxt_cmd_page = '0;
                  nxt_cmd_offset = '0;
               end
            end
         end
         ST_ADDR: begin
            if (byte_done) begin
               nxt_addr = addr_full;
               nxt_acnt = acnt_ff + 1'b1;
               if (acnt_ff == ADDR_BYTES - 2'h1) begin
                  // (RL3) filler bytes follow address
                  if (dummy_need != DUMMY_NONE) begin
                     nxt_state = ST_DUMMY;
                  end else begin
                     nxt_state = ST_DATA;
                     nxt_cmd_valid = 1'b1;
                  end
               end else begin
                  nxt_cmd_page = cmd_page_ff;
                  nxt_cmd_offset = cmd_offset_ff;
               end
            end else begin
               nxt_cmd_page = cmd_page_ff;
               nxt_cmd_offset = cmd_offset_ff;
            end
         end
         ST_DUMMY: begin
            if (byte_done) begin
               nxt_dcnt = dcnt_ff - 1'b1;
               if (dcnt_ff == DUMMY_ONE) begin
                  nxt_state = ST_DATA;
                  nxt_cmd_valid = 1'b1;
               end
            end
         end
         ST_DATA: begin
            // Full buffer drops bytes; host sees busy and must poll
            fifo_in_valid = byte_done;
         end
         ST_IGNORE: nxt_state = ST_IGNORE;
         default: nxt_state = ST_POR;
      endcase
      if (state_ff != ST_POR && state_ff != ST_STANDBY && cs_rise) begin
         nxt_state = ST_STANDBY;
         nxt_standby = 1'b1;
      end
      // (RL8) power-on reset overrides state, flags, clock mode and FIFO writes
      if (por_s) begin
         nxt_state = ST_POR;
         nxt_standby = 1'b0;
         nxt_cmd_valid = 1'b0;
         nxt_reject = 1'b0;
         nxt_mode3 = MODE3_AT_RESET;
         fifo_in_valid = 1'b0;
      end
      nxt_wcnt = wcnt_ff;
      nxt_write_ok = write_ok_ff;
      if (por_s) begin
         nxt_wcnt = '0;
         nxt_write_ok = 1'b0;
      end else if (!write_ok_ff) begin
         nxt_wcnt = wcnt_ff + 1'b1;
         nxt_write_ok = (wcnt_ff == WCNT_W'(POWER_UP_WRITE_CNT - 1));
      end
      nxt_ready = fifo_in_ready && !por_s && nxt_state != ST_POR;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         // (RL4) mode 3 and released outputs
         state_ff <= ST_POR;
         mode3_ff <= MODE3_AT_RESET;
         so_oe_n_ff <= OE_N_RESET;
         lanes_oe_n_ff <= OE_N_RESET;
         lclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b0;
         mode_byte_ff <= 1'b0;
         shift_ff <= '0;
         bitcnt_ff <= '0;
         opcode_ff <= '0;
         addr_ff <= '0;
         acnt_ff <= '0;
         dcnt_ff <= '0;
         wcnt_ff <= '0;
         write_ok_ff <= 1'b0;
         standby_ff <= 1'b0;
         ready_ff <= 1'b0;
         cmd_valid_ff <= 1'b0;
         cmd_opcode_ff <= '0;
         cmd_page_ff <= '0;
         cmd_offset_ff <= '0;
         reject_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         mode3_ff <= nxt_mode3;
         lclk_d_ff <= nxt_lclk_d;
         cs_d_ff <= nxt_cs_d;
         mode_byte_ff <= nxt_mode_byte;
         shift_ff <= nxt_shift;
         bitcnt_ff <= nxt_bitcnt;
         opcode_ff <= nxt_opcode;
         addr_ff <= nxt_addr;
         acnt_ff <= nxt_acnt;
         dcnt_ff <= nxt_dcnt;
         wcnt_ff <= nxt_wcnt;
         write_ok_ff <= nxt_write_ok;
         standby_ff <= nxt_standby;
         ready_ff <= nxt_ready;
         cmd_valid_ff <= nxt_cmd_valid;
         cmd_opcode_ff <= nxt_cmd_opcode;
         cmd_page_ff <= nxt_cmd_page;
         cmd_offset_ff <= nxt_cmd_offset;
         reject_ff <= nxt_reject;
      end
   end

   fcf_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .ce(ce),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(rx_byte),
      .out_valid(data_valid),
      .out_ready(data_ready),
      .out_data(data_byte)
   );

   // No read path in this block, so outputs never drive
   assign ser_out = 1'b0;
   assign ser_out_oe_n = so_oe_n_ff;
   assign byte_port_lanes_out = '0;
   assign byte_port_lanes_oe_n = lanes_oe_n_ff;
   assign clk_mode3 = mode3_ff;
   assign standby = standby_ff;
   assign write_allowed = write_ok_ff;
   assign ready_busy = ready_ff;
   assign cmd_valid = cmd_valid_ff;
   assign cmd_opcode = cmd_opcode_ff;
   assign cmd_page = cmd_page_ff;
   assign cmd_offset = cmd_offset_ff;
   assign cmd_rejected = reject_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset || !ce);

   sequence s_leave_standby;
      (state_ff == ST_STANDBY) ##1 (state_ff == ST_OPCODE);
   endsequence
   sequence s_enter_dummy;
      (state_ff == ST_ADDR) ##1 (state_ff == ST_DUMMY);
   endsequence

   property p_por_defaults; // RL4
      (state_ff == ST_POR) |-> (mode3_ff && so_oe_n_ff && lanes_oe_n_ff);
   endproperty
   a_por_defaults: assert property (p_por_defaults) // RL4
      else $error("outputs not released or mode not 3 in power-on reset");
   property p_start_on_fall; // RL5
      s_leave_standby |-> $past(cs_fall);
   endproperty
   a_start_on_fall: assert property (p_start_on_fall) // RL5
      else $error("instruction started without select fall");
   property p_mode_pick; // RL6
      s_leave_standby |-> (mode3_ff == $past(lclk_s));
   endproperty
   a_mode_pick: assert property (p_mode_pick) // RL6
      else $error("clock mode not taken from idle clock level");
   property p_por_ignore; // RL8
      por_s |=> (state_ff == ST_POR && !cmd_valid_ff && !cmd_rejected);
   endproperty
   a_por_ignore: assert property (p_por_ignore) // RL8
      else $error("activity while power-on reset active");
   property p_standby_after; // RL10
      (state_ff == ST_POR && !por_s) |=> (state_ff == ST_STANDBY && standby);
   endproperty
   a_standby_after: assert property (p_standby_after) // RL10
      else $error("no standby after power-up");
   property p_page_byte; // RL1
      (cmd_valid_ff && fcf_addr_kind(cmd_opcode_ff) == AK_PAGE_BYTE) |->
         (cmd_page_ff == addr_ff[ADDR_W-1:OFFS_W] &&
          cmd_offset_ff == addr_ff[OFFS_W-1:0]);
   endproperty
   a_page_byte: assert property (p_page_byte) // RL1
      else $error("page or offset field misplaced");
   property p_buffer_mask; // RL2
      (cmd_valid_ff && fcf_addr_kind(cmd_opcode_ff) == AK_BUFFER) |->
         (cmd_page_ff == '0 && cmd_offset_ff == addr_ff[OFFS_W-1:0]);
   endproperty
   a_buffer_mask: assert property (p_buffer_mask) // RL2
      else $error("buffer opcode did not mask page bits");
   property p_dummy_load; // RL3
      s_enter_dummy |-> (dcnt_ff == fcf_dummy(opcode_ff, mode_byte_ff));
   endproperty
   a_dummy_load: assert property (p_dummy_load) // RL3
      else $error("wrong filler byte count");
   property p_dummy_end; // RL3
      (state_ff == ST_DUMMY && byte_done && dcnt_ff == DUMMY_ONE && !por_s
       && !cs_rise) |=> (state_ff == ST_DATA && cmd_valid_ff);
   endproperty
   a_dummy_end: assert property (p_dummy_end) // RL3
      else $error("framing did not end after last filler byte");
   property p_byte_lane; // RL12
      (mode_byte_ff && lclk_rise && !cs_s && state_ff == ST_DATA && !por_s
       && fifo_in_ready) |=> data_valid;
   endproperty
   a_byte_lane: assert property (p_byte_lane) // RL12
      else $error("byte port clock edge did not deliver a byte");
endmodule

// ### fcf_host.sv
`timescale 1ns/10ps
module fcf_host (
   output logic cs_n,
   output logic ser_clk,
   output logic ser_in,
   output logic byte_clk,
   output logic byte_sel,
   output logic [7:0] lanes
);
   logic wide_ff;
   initial begin
      cs_n = 1'b1;
      ser_clk = 1'b1;
      ser_in = 1'b0;
      byte_clk = 1'b1;
      byte_sel = 1'b0;
      lanes = 8'h00;
      wide_ff = 1'b0;
   end
   // fresh select fall, idle clock picks mode
   task automatic open_frame(input logic idle_hi, input logic wide);
      wide_ff = wide;
      byte_sel = wide;
      ser_clk = idle_hi;
      #40 cs_n = 1'b0;
      #40;
   endtask
   // serial MSB first, one byte per byte-port clock
   task automatic put(input logic [7:0] b);
      if (wide_ff) begin
         byte_clk = 1'b0;
         lanes = b;
         #40 byte_clk = 1'b1;
         #40;
      end else begin
         for (int i = 7; i >= 0; i--) begin
            ser_clk = 1'b0;
            ser_in = b[i];
            #40 ser_clk = 1'b1;
            #40;
         end
      end
   endtask
   // Released lines invert so stale values never look valid
   task automatic close_frame(input logic idle_hi);
      ser_clk = idle_hi;
      #40 cs_n = 1'b1;
      ser_in = ~ser_in;
      lanes = ~lanes;
      #120;
   endtask
endmodule

// ### tb_flash_cmd_framing_powerup.sv
`timescale 1ns/10ps
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin \
   n_fail++; $display("BAD %0t %s", $time, m); end end
module tb_flash_cmd_framing_powerup
   import fcf_pkg::*;
;
   logic ref_clk, reset, ce, por_active, data_ready;
   logic cs_n, ser_clk, ser_in, byte_clk, byte_sel;
   logic [7:0] lanes, lanes_out, cmd_opcode, data_byte;
   logic ser_out, ser_out_oe_n, lanes_oe_n, clk_mode3, standby;
   logic write_allowed, ready_busy, cmd_valid, cmd_rejected, data_valid;
   logic [PAGE_W-1:0] cmd_page;
   logic [OFFS_W-1:0] cmd_offset;
   int n_fail = 0;
   int tests_run = 0;
   int n_valid = 0;
   int n_rej = 0;
   fcf_framer #(.POWER_UP_WRITE_CNT(200)) fcf_framer_i (
      .ref_clk(ref_clk), .reset(reset), .ce(ce),
      .por_active(por_active), .cs_n(cs_n), .ser_clk(ser_clk),
      .ser_in(ser_in), .byte_clk(byte_clk), .byte_sel(byte_sel),
      .byte_port_lanes_in(lanes), .ser_out(ser_out),
      .ser_out_oe_n(ser_out_oe_n), .byte_port_lanes_out(lanes_out),
      .byte_port_lanes_oe_n(lanes_oe_n), .clk_mode3(clk_mode3),
      .standby(standby), .write_allowed(write_allowed),
      .ready_busy(ready_busy), .cmd_valid(cmd_valid),
      .cmd_opcode(cmd_opcode), .cmd_page(cmd_page),
      .cmd_offset(cmd_offset), .cmd_rejected(cmd_rejected),
      .data_valid(data_valid), .data_ready(data_ready),
      .data_byte(data_byte));
   fcf_host fcf_host_i (.cs_n(cs_n), .ser_clk(ser_clk), .ser_in(ser_in),
      .byte_clk(byte_clk), .byte_sel(byte_sel), .lanes(lanes));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      n_valid <= n_valid + int'(cmd_valid === 1'b1);
      n_rej <= n_rej + int'(cmd_rejected === 1'b1);
   end
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic hdr(input logic [7:0] op, input logic [23:0] a,
                      input logic idle_hi, input logic w);
      fcf_host_i.open_frame(idle_hi, w);
      fcf_host_i.put(op);
      fcf_host_i.put(a[23:16]);
      fcf_host_i.put(a[15:8]);
      fcf_host_i.put(a[7:0]);
      repeat (6) @(negedge ref_clk);
   endtask
   task automatic t_reset;
      repeat (3) @(negedge ref_clk);
      `CHK(clk_mode3, 1'b1, "mode after reset")
      `CHK({ser_out_oe_n, lanes_oe_n}, 2'b11, "outputs driven")
      `CHK({ser_out, lanes_out}, 9'h000, "output data not idle")
      `CHK(standby, 1'b1, "not standby")
      `CHK(write_allowed, 1'b0, "write too early")
      repeat (250) @(negedge ref_clk);
      `CHK(write_allowed, 1'b1, "write never allowed")
      $display("done reset");
   endtask
   task automatic t_por;
      int v, r;
      por_active = 1'b1;
      repeat (5) @(negedge ref_clk);
      `CHK({standby, ready_busy}, 2'b00, "active in por")
      v = n_valid;
      hdr(OP_84, 24'h000123, 1'b1, 1'b0);
      fcf_host_i.close_frame(1'b1);
      `CHK(n_valid, v, "command in por")
      por_active = 1'b0;
      repeat (5) @(negedge ref_clk);
      r = n_rej;
      hdr(OP_82, 24'h000123, 1'b1, 1'b0);
      fcf_host_i.close_frame(1'b1);
      `CHK(n_rej, r + 1, "early write kept")
      `CHK(n_valid, v, "early write framed")
      repeat (250) @(negedge ref_clk);
      $display("done por");
   endtask
   task automatic t_addr(input logic [7:0] op, input logic [23:0] a,
                         input logic [PAGE_W-1:0] pg,
                         input logic [OFFS_W-1:0] of, input logic idle_hi);
      int v;
      v = n_valid;
      hdr(op, a, idle_hi, 1'b0);
      `CHK(n_valid, v + 1, "no frame end")
      `CHK({cmd_opcode, cmd_page, cmd_offset}, {op, pg, of}, "fields")
      `CHK(clk_mode3, idle_hi, "mode pick")
      if (op != OP_84)
         fcf_host_i.close_frame(idle_hi);
      $display("done addr %h", op);
   endtask
   task automatic t_fifo;
      t_addr(OP_84, 24'hFFFFFF, 13'h0000, 11'h7FF, 1'b0);
      for (int k = 1; k <= 5; k++)
         fcf_host_i.put(8'(k * 8'h11));
      repeat (6) @(negedge ref_clk);
      `CHK({ready_busy, data_valid}, 2'b01, "fifo not full")
      data_ready = 1'b1;
      for (int k = 1; k <= 4; k++) begin
         `CHK(data_byte, 8'(k * 8'h11), "data order")
         @(negedge ref_clk);
      end
      data_ready = 1'b0;
      `CHK({ready_busy, data_valid}, 2'b10, "fifo not empty")
      fcf_host_i.close_frame(1'b0);
      $display("done fifo");
   endtask
   task automatic t_fill(input logic [7:0] op, input logic w, input int n);
      int v;
      v = n_valid;
      hdr(op, 24'h012345, 1'b1, w);
      for (int i = 0; i <= n; i++) begin
         if (i > 0) begin
            fcf_host_i.put(8'hA5);
            repeat (6) @(negedge ref_clk);
         end
         `CHK(n_valid - v, (i == n) ? 1 : 0, "filler count")
      end
      fcf_host_i.put(8'h3C);
      repeat (6) @(negedge ref_clk);
      `CHK({data_valid, data_byte}, 9'h13C, "data after filler")
      data_ready = 1'b1;
      @(negedge ref_clk);
      data_ready = 1'b0;
      fcf_host_i.close_frame(1'b1);
      $display("done fill %h", op);
   endtask
   task automatic t_ce;
      int v;
      v = n_valid;
      ce = 1'b0;
      hdr(OP_82, 24'h000001, 1'b1, 1'b0);
      fcf_host_i.close_frame(1'b1);
      `CHK({n_valid, standby}, {v, 1'b1}, "frozen core moved")
      ce = 1'b1;
      repeat (5) @(negedge ref_clk);
      $display("done ce");
   endtask
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      por_active = 1'b0;
      data_ready = 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      t_reset;
      t_por;
      t_addr(OP_82, 24'hABCDEF, 13'h1579, 11'h5EF, 1'b1);
      t_addr(OP_7C, 24'hFFFFFF, 13'h1F00, 11'h000, 1'b1);
      t_fifo;
      t_fill(OP_D2, 1'b0, 4);
      t_fill(OP_E8, 1'b1, 19);
      t_fill(OP_77, 1'b1, 4);
      t_fill(OP_D4, 1'b0, 1);
      t_ce;
      test_done;
   end
   initial begin
      #900000;
      n_fail++;
      test_done;
   end
endmodule
